// File: design/display_extension_regs.sv
// display extension registers behind the sequencer and crtc ports
`timescale 1ns/1ps
`include "ext_defines.svh"
// How it works
// power save disables video data paths; memory gets refresh cycles only
// power save stops gray and half-frame clocks and gates data path clock
// force-eight-dots runs nine-dot text modes with eight dots
// clock-halve bit divides selected external clock by two
// crystal-drive bit turns clock input pins into crystal drive outputs
// bios reads of the top 8K take the three page bits on top
// rom page field resets to 011, the top page
// line compare match loads row scan counter from split preset
// split preset and start clear on reset or sync reset bit zero
// split start is a 16-bit address from high and low bytes
// two read-only revision registers ignore writes
// retrace start is a nine-bit line, ninth bit from overflow register
// retrace start write-only at crtc 10, readable at extension 90
// retrace end write-only at crtc 11, readable at extension 91
// retrace registers act only in the vga adapter state
// interrupt enabled while enable bit is zero; resets disabled
// clear bit at zero clears the pending interrupt; resets zero
// retrace ends when counter low four bits equal end field
// software programs end as low bits of start plus width
// compatibility test bit forces line counter bits 7-8 high
// top test bit of retrace end is ignored
// line counter clears at vertical total
// interrupt latches at retrace start and holds until cleared
module display_extension_regs #(
  parameter logic [7:0] GFX_REV_CODE = 8'h5A, // arbitrary value
  parameter logic [7:0] SEQ_REV_CODE = 8'h3C  // arbitrary value
) (
  input  wire logic        CLK,
  input  wire logic        RESET,
  input  wire logic [9:0]  IO_ADDR,
  input  wire logic        IO_WR,
  input  wire logic        IO_RD,
  input  wire logic [7:0]  IO_WDATA,
  output logic      [7:0]  IO_RDATA,
  input  wire logic [7:0]  PEN_ADDR_HIGH,
  input  wire logic [7:0]  PEN_ADDR_LOW,
  input  wire logic        LINE_TICK,
  input  wire logic        ADAPTER_VGA,
  input  wire logic        BIOS_RD,
  input  wire logic [14:0] BIOS_ADDR,
  output logic      [15:0] ROM_ADDR,
  output logic             ROM_PAGED,
  output logic             GRAY_CLK_EN,
  output logic             HFB_CLK_EN,
  output logic             DATAPATH_CLK_EN,
  output logic             REFRESH_ONLY,
  output logic             EIGHT_DOT_TEXT,
  output logic             CLK_HALVE,
  output logic             XTAL_PIN_OE,
  output logic             ROW_PRESET_LOAD,
  output logic      [4:0]  ROW_PRESET,
  output logic      [15:0] SPLIT_START,
  output logic             VRETRACE,
  output logic      [9:0]  VLINE,
  output logic             VERTICAL_INTERRUPT_OUT
);
  ext_pkg::regs_s q;
  ext_pkg::regs_s n;
  logic [9:0] line;
  logic       line_start;
  logic [9:0] vtotal_full;
  logic       rs_hit;
  logic       re_hit;
  logic       lc_hit;
  logic       irq_set;

  // ovf and compare bits combine into the wide timing values
  assign vtotal_full = {q.ovf[`OVF_VT9_BIT], q.ovf[`OVF_VT8_BIT], q.vtotal};
  assign rs_hit = line_start && ADAPTER_VGA
                  && line[8:0] == {q.ovf[`OVF_VRS8_BIT], q.vrs};
  assign re_hit = line_start && line[3:0] == q.vre[3:0];
  assign lc_hit = line_start && line[8:0] == {q.ovf[`OVF_LC8_BIT], q.lcmp};
  assign irq_set = rs_hit && q.rt == ext_pkg::RT_IDLE
                   && !q.vre[`IRQ_EN_N_BIT];

  line_counter u_line (
    .clk          (CLK),
    .reset        (RESET),
    .line_tick    (LINE_TICK),
    .vtotal       (vtotal_full),
    .compat_force (q.vre[`COMPAT_BIT]),
    .line         (line),
    .line_start   (line_start)
  );

  rom_page_map u_rom (
    .clk      (CLK),
    .reset    (RESET),
    .bios_rd  (BIOS_RD),
    .bus_addr (BIOS_ADDR),
    .page     (q.panel[2:0]),
    .rom_addr (ROM_ADDR),
    .paged    (ROM_PAGED)
  );

  function automatic logic [7:0] read_value(input ext_pkg::regs_s r,
                                            input logic [9:0] a);
    read_value = 8'h00;
    case (a)
      `PORT_ISR0: read_value = {r.irq, 7'h00};
      `PORT_SEQ_IDX: read_value = r.seq_idx;
      `PORT_CRTC_IDX_M, `PORT_CRTC_IDX_C: read_value = r.crtc_idx;
      `PORT_SEQ_DAT: begin
        case (r.seq_idx)
          `SEQ_RESET_IDX: read_value = r.sync_ctl;
          `PANEL_IDX: read_value = r.panel;
          `PRESET_IDX: read_value = r.preset;
          `START_HI_IDX: read_value = r.start_hi;
          `START_LO_IDX: read_value = r.start_lo;
          `GFX_REV_IDX: read_value = GFX_REV_CODE;
          `SEQ_REV_IDX: read_value = SEQ_REV_CODE;
          `VRS_SHADOW_IDX: read_value = r.vrs;
          `VRE_SHADOW_IDX: read_value = r.vre;
          default: read_value = 8'h00;
        endcase
      end
      `PORT_CRTC_DAT_M, `PORT_CRTC_DAT_C: begin
        case (r.crtc_idx)
          `CRTC_VTOTAL_IDX: read_value = r.vtotal;
          `CRTC_OVF_IDX: read_value = r.ovf;
          `CRTC_VRS_IDX: read_value = PEN_ADDR_HIGH;
          `CRTC_VRE_IDX: read_value = PEN_ADDR_LOW;
          `CRTC_LCMP_IDX: read_value = r.lcmp;
          default: read_value = 8'h00;
        endcase
      end
      default: read_value = 8'h00;
    endcase
  endfunction

  always_comb begin
    n = q;
    n.load = 1'h0;
    if (IO_WR) begin
      case (IO_ADDR)
        `PORT_SEQ_IDX: n.seq_idx = IO_WDATA;
        `PORT_CRTC_IDX_M, `PORT_CRTC_IDX_C: n.crtc_idx = IO_WDATA;
        `PORT_SEQ_DAT: begin
          case (q.seq_idx)
            `SEQ_RESET_IDX: n.sync_ctl = IO_WDATA;
            `PANEL_IDX: n.panel = IO_WDATA;
            `PRESET_IDX: n.preset = {3'h0, IO_WDATA[4:0]};
            `START_HI_IDX: n.start_hi = IO_WDATA;
            `START_LO_IDX: n.start_lo = IO_WDATA;
            `VRS_SHADOW_IDX: n.vrs = IO_WDATA;
            `VRE_SHADOW_IDX: n.vre = IO_WDATA;
            default: n.seq_idx = q.seq_idx; // revision codes ignore writes
          endcase
        end
        `PORT_CRTC_DAT_M, `PORT_CRTC_DAT_C: begin
          case (q.crtc_idx)
            `CRTC_VTOTAL_IDX: n.vtotal = IO_WDATA;
            `CRTC_OVF_IDX: n.ovf = IO_WDATA;
            `CRTC_VRS_IDX: n.vrs = IO_WDATA;
            `CRTC_VRE_IDX: n.vre = IO_WDATA;
            `CRTC_LCMP_IDX: n.lcmp = IO_WDATA;
            default: n.crtc_idx = q.crtc_idx;
          endcase
        end
        default: n.rdata = q.rdata;
      endcase
    end
    // sync reset wins over a same-cycle write to the split registers
    if (!n.sync_ctl[`SYNC_RST_BIT]) begin
      n.preset   = `ZERO_RST;
      n.start_hi = `ZERO_RST;
      n.start_lo = `ZERO_RST;
    end
    if (IO_RD) begin
      n.rdata = read_value(q, IO_ADDR);
    end
    // retrace only starts in vga state; leaving the state ends it
    case (q.rt)
      ext_pkg::RT_IDLE: begin
        if (rs_hit) begin
          n.rt = ext_pkg::RT_ACTIVE;
        end
      end
      ext_pkg::RT_ACTIVE: begin
        if (re_hit || !ADAPTER_VGA) begin
          n.rt = ext_pkg::RT_IDLE;
        end
      end
      default: n.rt = ext_pkg::RT_IDLE;
    endcase
    n.vret = n.rt == ext_pkg::RT_ACTIVE;
    // set wins over a clear held in the same cycle
    n.irq = irq_set || (q.irq && n.vre[`IRQ_CLR_N_BIT]);
    n.load = lc_hit;
    n.row = n.preset[4:0];
    n.split = {n.start_hi, n.start_lo};
    // bit 7 of retrace end is never read here
    n.ctl = {~n.panel[`PS_BIT], n.panel[`PS_BIT], n.panel[`EIGHT_DOT_BIT],
             n.panel[`HALVE_BIT], n.panel[`XTAL_BIT], 1'h0};
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      q          <= '0;
      q.sync_ctl <= `SYNC_CTL_RST;
      q.panel    <= `PANEL_RST;
      q.vre      <= `VRE_RST;
      q.vtotal   <= `VTOTAL_RST;
      q.ctl      <= 6'h20;
      q.rt       <= ext_pkg::RT_IDLE;
    end else begin
      q <= n;
    end
  end

  // gray, half-frame and data path clock enables all drop together in power save
  assign GRAY_CLK_EN            = q.ctl[5];
  assign HFB_CLK_EN             = q.ctl[5];
  assign DATAPATH_CLK_EN        = q.ctl[5];
  assign REFRESH_ONLY           = q.ctl[4];
  assign EIGHT_DOT_TEXT         = q.ctl[3];
  assign CLK_HALVE              = q.ctl[2];
  assign XTAL_PIN_OE            = q.ctl[1];
  assign IO_RDATA               = q.rdata;
  assign ROW_PRESET_LOAD        = q.load;
  assign ROW_PRESET             = q.row;
  assign SPLIT_START            = q.split;
  assign VRETRACE               = q.vret;
  assign VLINE                  = line;
  assign VERTICAL_INTERRUPT_OUT = q.irq;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (RESET);

  sequence s_seq_wr(logic [7:0] idx);
    IO_WR && IO_ADDR == 10'h3C5 && q.seq_idx == idx;
  endsequence

  sequence s_seq_rd(logic [7:0] idx);
    IO_RD && IO_ADDR == 10'h3C5 && q.seq_idx == idx;
  endsequence

  property p_refresh;
    s_seq_wr(8'h8A) ##0 IO_WDATA[7] |=> REFRESH_ONLY;
  endproperty
  a_refresh: assert property (p_refresh) else $error("power save not entered");

  property p_clk_gate;
    REFRESH_ONLY |-> !GRAY_CLK_EN && !HFB_CLK_EN && !DATAPATH_CLK_EN;
  endproperty
  a_clk_gate: assert property (p_clk_gate) else $error("clocks run in power save");

  property p_panel_bits;
    s_seq_wr(8'h8A) |=> EIGHT_DOT_TEXT == $past(IO_WDATA[6])
      && CLK_HALVE == $past(IO_WDATA[4]) && XTAL_PIN_OE == $past(IO_WDATA[3]);
  endproperty
  a_panel_bits: assert property (p_panel_bits) else $error("panel bits wrong");

  property p_page_reset;
    $past(RESET) |-> q.panel[2:0] == 3'h3;
  endproperty
  a_page_reset: assert property (p_page_reset) else $error("rom page reset wrong");

  property p_row_load;
    lc_hit |=> ROW_PRESET_LOAD && ROW_PRESET == q.preset[4:0] ##1 !ROW_PRESET_LOAD;
  endproperty
  a_row_load: assert property (p_row_load) else $error("row preset not loaded");

  property p_sync_clear;
    !q.sync_ctl[1] |-> q.preset == 8'h00 && SPLIT_START == 16'h0000;
  endproperty
  a_sync_clear: assert property (p_sync_clear) else $error("split regs not cleared");

  property p_rev;
    s_seq_rd(8'h8E) |=> IO_RDATA == GFX_REV_CODE;
  endproperty
  a_rev: assert property (p_rev) else $error("revision code wrong");

  property p_pen_high;
    IO_RD && IO_ADDR == 10'h3D5 && q.crtc_idx == 8'h10 |=> IO_RDATA == $past(PEN_ADDR_HIGH);
  endproperty
  a_pen_high: assert property (p_pen_high) else $error("crtc 10 read not pen high");

  property p_vga_only;
    !VRETRACE && !ADAPTER_VGA |=> !VRETRACE;
  endproperty
  a_vga_only: assert property (p_vga_only) else $error("retrace outside vga state");

  property p_retrace_start;
    rs_hit && !VRETRACE |=> VRETRACE;
  endproperty
  a_retrace_start: assert property (p_retrace_start) else $error("retrace not started");

  property p_retrace_end;
    VRETRACE && re_hit |=> !VRETRACE;
  endproperty
  a_retrace_end: assert property (p_retrace_end) else $error("retrace not ended");

  property p_irq_set;
    irq_set |=> VERTICAL_INTERRUPT_OUT;
  endproperty
  a_irq_set: assert property (p_irq_set) else $error("interrupt not latched");

  property p_irq_off;
    q.vre[5] && !VERTICAL_INTERRUPT_OUT ##1 q.vre[5] |-> !VERTICAL_INTERRUPT_OUT;
  endproperty
  a_irq_off: assert property (p_irq_off) else $error("disabled interrupt raised");

  property p_irq_clear;
    !q.vre[4] && !irq_set ##1 !irq_set |-> !VERTICAL_INTERRUPT_OUT;
  endproperty
  a_irq_clear: assert property (p_irq_clear) else $error("interrupt not cleared");

  // both crtc port pairs reach the same registers
  sequence s_crt_wr(logic [7:0] idx);
    IO_WR && (IO_ADDR == 10'h3D5 || IO_ADDR == 10'h3B5) && q.crtc_idx == idx;
  endsequence

  sequence s_crt_rd(logic [7:0] idx);
    IO_RD && (IO_ADDR == 10'h3D5 || IO_ADDR == 10'h3B5) && q.crtc_idx == idx;
  endsequence

  property p_split_high;
    s_seq_wr(8'h8C) ##0 q.sync_ctl[1] |=> SPLIT_START[15:8] == $past(IO_WDATA);
  endproperty
  a_split_high: assert property (p_split_high) else $error("split high byte wrong");

  property p_split_low;
    s_seq_wr(8'h8D) ##0 q.sync_ctl[1] |=> SPLIT_START[7:0] == $past(IO_WDATA);
  endproperty
  a_split_low: assert property (p_split_low) else $error("split low byte wrong");

  property p_sync_preset;
    s_seq_wr(8'h00) ##0 !IO_WDATA[1] |=> ROW_PRESET == 5'h00 && SPLIT_START == 16'h0000;
  endproperty
  a_sync_preset: assert property (p_sync_preset) else $error("sync reset kept split");

  property p_rev_seq;
    s_seq_rd(8'h8F) |=> IO_RDATA == SEQ_REV_CODE;
  endproperty
  a_rev_seq: assert property (p_rev_seq) else $error("seq revision wrong");

  property p_pen_low;
    s_crt_rd(8'h11) |=> IO_RDATA == $past(PEN_ADDR_LOW);
  endproperty
  a_pen_low: assert property (p_pen_low) else $error("crtc 11 read not pen low");

  property p_vre_crtc;
    s_crt_wr(8'h11) |=> q.vre == $past(IO_WDATA);
  endproperty
  a_vre_crtc: assert property (p_vre_crtc) else $error("crtc 11 write lost");
endmodule // display_extension_regs

// File: design/ext_defines.svh
// constants for the display extension register bank
`ifndef EXT_DEFINES_SVH
`define EXT_DEFINES_SVH
`define PORT_ISR0         10'h3C2
`define PORT_SEQ_IDX      10'h3C4
`define PORT_SEQ_DAT      10'h3C5
`define PORT_CRTC_IDX_M   10'h3B4
`define PORT_CRTC_DAT_M   10'h3B5
`define PORT_CRTC_IDX_C   10'h3D4
`define PORT_CRTC_DAT_C   10'h3D5
`define SEQ_RESET_IDX     8'h00
`define PANEL_IDX         8'h8A
`define PRESET_IDX        8'h8B
`define START_HI_IDX      8'h8C
`define START_LO_IDX      8'h8D
`define GFX_REV_IDX       8'h8E
`define SEQ_REV_IDX       8'h8F
`define VRS_SHADOW_IDX    8'h90
`define VRE_SHADOW_IDX    8'h91
`define CRTC_VTOTAL_IDX   8'h06
`define CRTC_OVF_IDX      8'h07
`define CRTC_VRS_IDX      8'h10
`define CRTC_VRE_IDX      8'h11
`define CRTC_LCMP_IDX     8'h18
`define SYNC_RST_BIT      1
`define PS_BIT            7
`define EIGHT_DOT_BIT     6
`define HALVE_BIT         4
`define XTAL_BIT          3
`define IRQ_EN_N_BIT      5
`define IRQ_CLR_N_BIT     4
`define COMPAT_BIT        6
`define OVF_VT8_BIT       0
`define OVF_VRS8_BIT      2
`define OVF_LC8_BIT       4
`define OVF_VT9_BIT       5
`define ISR0_IRQ_BIT      7
`define ROM_TOP_PAGE      2'h3
`define PANEL_RST         8'h03
`define SYNC_CTL_RST      8'h03
`define VRE_RST           8'h20
`define VTOTAL_RST        8'hFF
`define ZERO_RST          8'h00
`endif

// File: design/ext_pkg.sv
// types shared by the display extension register bank
package ext_pkg;
  typedef enum logic [0:0] {RT_IDLE = 1'h0, RT_ACTIVE = 1'h1} retrace_e;
  typedef struct packed {
    logic [7:0]  seq_idx;
    logic [7:0]  crtc_idx;
    logic [7:0]  sync_ctl;
    logic [7:0]  panel;
    logic [7:0]  preset;
    logic [7:0]  start_hi;
    logic [7:0]  start_lo;
    logic [7:0]  vrs;
    logic [7:0]  vre;
    logic [7:0]  ovf;
    logic [7:0]  vtotal;
    logic [7:0]  lcmp;
    logic [7:0]  rdata;
    logic        irq;
    retrace_e    rt;
    logic        vret;
    logic        load;
    logic [4:0]  row;
    logic [15:0] split;
    logic [5:0]  ctl;
  } regs_s;
  typedef struct packed {
    logic [9:0] cnt;
    logic [9:0] eff;
    logic       start;
  } line_s;
  typedef struct packed {
    logic [15:0] addr;
    logic        paged;
  } rom_s;
endpackage

// File: design/line_counter.sv
// vertical scan line counter with compatibility forcing
`timescale 1ns/1ps
`include "ext_defines.svh"
module line_counter (
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       line_tick,
  input  wire logic [9:0] vtotal,
  input  wire logic       compat_force,
  output logic      [9:0] line,
  output logic            line_start
);
  ext_pkg::line_s q;
  ext_pkg::line_s n;

  always_comb begin
    n = q;
    n.start = line_tick;
    if (line_tick) begin
      n.cnt = (q.cnt == vtotal) ? 10'h000 : q.cnt + 10'h001;
    end
    n.eff = n.cnt;
    if (compat_force) begin
      n.eff[8:7] = 2'h3;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign line       = q.eff;
  assign line_start = q.start;

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  property p_wrap;
    line_tick && q.cnt == vtotal |=> q.cnt == 10'h000 && line_start;
  endproperty
  a_wrap: assert property (p_wrap) else $error("line count did not clear at total");

  property p_compat;
    compat_force ##1 compat_force |-> line[8:7] == 2'h3;
  endproperty
  a_compat: assert property (p_compat) else $error("line bits 7-8 not forced");
endmodule // line_counter

// File: design/rom_page_map.sv
// bios rom address paging for the top 8K of the segment
`timescale 1ns/1ps
`include "ext_defines.svh"
module rom_page_map (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        bios_rd,
  input  wire logic [14:0] bus_addr,
  input  wire logic [2:0]  page,
  output logic      [15:0] rom_addr,
  output logic             paged
);
  ext_pkg::rom_s q;
  ext_pkg::rom_s n;

  always_comb begin
    n.paged = bios_rd && bus_addr[14:13] == `ROM_TOP_PAGE;
    n.addr  = n.paged ? {page, bus_addr[12:0]} : {1'h0, bus_addr};
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign rom_addr = q.addr;
  assign paged    = q.paged;

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  property p_page;
    bios_rd && bus_addr[14:13] == 2'h3
      |=> paged && rom_addr == {$past(page), $past(bus_addr[12:0])};
  endproperty
  a_page: assert property (p_page) else $error("rom page not substituted");
endmodule // rom_page_map

// File: verif/display_extension_regs_tb.sv
// self-checking bench for the display extension register bank
`timescale 1ns/1ps
module display_extension_regs_tb;
  localparam logic [7:0] GFX_REV = 8'h5A; // arbitrary value
  localparam logic [7:0] SEQ_REV = 8'hC3; // arbitrary value
  logic        clk, reset, io_wr, io_rd, line_tick, adapter_vga, bios_rd;
  logic        rom_paged, gray_en, hfb_en, dp_en, refresh_only, eight_dot;
  logic        clk_halve, xtal_oe, row_load, vretrace, irq;
  logic [9:0]  io_addr, vline, rise;
  logic [7:0]  io_wdata, io_rdata, q;
  logic [14:0] bios_addr;
  logic [15:0] rom_addr, split_start;
  logic [4:0]  row_preset;
  int          n_mismatch, comparisons, cycles, hi, ld;
  logic [7:0]  pdat [4] = '{8'h80, 8'h40, 8'h10, 8'h08};
  logic [6:0]  pexp [4] = '{7'b1000000, 7'b0111100, 7'b0111010, 7'b0111001};
  logic [15:0] radr [5] = '{16'h7ABC, 16'h5ABC, 16'h5FFF, 16'h6000, 16'h7ABC};
  logic [1:0]  rrd  [5] = '{2'b11, 2'b01, 2'b01, 2'b11, 2'b00};
  logic [15:0] rexp [5] = '{16'hBABC, 16'h5ABC, 16'h5FFF, 16'hA000, 16'h7ABC};

  display_extension_regs #(.GFX_REV_CODE(GFX_REV), .SEQ_REV_CODE(SEQ_REV))
    display_extension_regs_inst (
    .CLK(clk), .RESET(reset), .IO_ADDR(io_addr), .IO_WR(io_wr), .IO_RD(io_rd),
    .IO_WDATA(io_wdata), .IO_RDATA(io_rdata), .PEN_ADDR_HIGH(8'hA1),
    .PEN_ADDR_LOW(8'hB2), .LINE_TICK(line_tick), .ADAPTER_VGA(adapter_vga),
    .BIOS_RD(bios_rd), .BIOS_ADDR(bios_addr), .ROM_ADDR(rom_addr),
    .ROM_PAGED(rom_paged), .GRAY_CLK_EN(gray_en), .HFB_CLK_EN(hfb_en),
    .DATAPATH_CLK_EN(dp_en), .REFRESH_ONLY(refresh_only), .EIGHT_DOT_TEXT(eight_dot),
    .CLK_HALVE(clk_halve), .XTAL_PIN_OE(xtal_oe), .ROW_PRESET_LOAD(row_load),
    .ROW_PRESET(row_preset), .SPLIT_START(split_start), .VRETRACE(vretrace),
    .VLINE(vline), .VERTICAL_INTERRUPT_OUT(irq));

  host_bus host_bus_inst (.clk(clk), .io_rdata(io_rdata), .io_addr(io_addr),
    .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata));

  always #50 clk = ~clk;

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic settle;
    repeat (2) @(negedge clk);
  endtask

  task automatic tick;
    @(negedge clk);
    line_tick = 1'b1;
    @(negedge clk);
    line_tick = 1'b0;
    @(negedge clk);
  endtask

  // starts at line zero so one retrace never straddles the window
  task automatic frame(input int n);
    for (int k = 0; k < 1200 && vline !== 10'h000; k++) tick;
    hi   = 0;
    ld   = 0;
    rise = 10'h3FF;
    for (int k = 0; k < n; k++) begin
      tick;
      if (vretrace === 1'b1 && hi == 0) rise = vline;
      if (vretrace === 1'b1) hi++;
      if (row_load === 1'b1) ld++;
      if (vline[9:8] !== 2'b00 && vline[9] !== 1'b0) hi = 99;
    end
  endtask

  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      n_mismatch++;
      end_sim;
    end
  end

  initial begin
    clk = 0; reset = 1; line_tick = 0; adapter_vga = 1; bios_rd = 0;
    bios_addr = 15'h0000; n_mismatch = 0; comparisons = 0; cycles = 0;
    repeat (16) @(negedge clk);
    reset = 0;
    chk({refresh_only, gray_en, hfb_en, dp_en}, 16'h7, "clock enables");
    host_bus_inst.ext_rd(8'h8A, q); chk(q, 8'h03, "panel reset");
    for (int i = 8'h8B; i <= 8'h8D; i++) begin
      host_bus_inst.ext_rd(8'(i), q); chk(q, 8'h00, "split reset");
    end
    host_bus_inst.ext_rd(8'h91, q); chk(q[5:4], 2'b10, "irq bits");
    $display("test reset done");
    for (int i = 0; i < 4; i++) begin
      host_bus_inst.ext_wr(8'h8A, pdat[i]);
      settle;
      chk({refresh_only, gray_en, hfb_en, dp_en, eight_dot, clk_halve, xtal_oe},
          pexp[i], "panel bits");
    end
    $display("test panel done");
    for (int i = 0; i < 5; i++) begin
      host_bus_inst.ext_wr(8'h8A, (i == 4) ? 8'h03 : 8'h05);
      bios_rd = rrd[i][0];
      bios_addr = radr[i][14:0];
      settle;
      chk(rom_addr, rexp[i], "rom addr");
      chk(rom_paged, rrd[i][1], "rom paged");
    end
    bios_rd = 0;
    $display("test rom done");
    host_bus_inst.ext_wr(8'h8B, 8'h1F);
    host_bus_inst.ext_wr(8'h8C, 8'h12);
    host_bus_inst.ext_wr(8'h8D, 8'h34);
    settle;
    chk(split_start, 16'h1234, "split start");
    chk(row_preset, 5'h1F, "row preset");
    host_bus_inst.ext_rd(8'h8C, q); chk(q, 8'h12, "split high");
    host_bus_inst.ext_wr(8'h00, 8'h01);
    host_bus_inst.ext_wr(8'h8C, 8'h77);
    settle;
    chk({split_start, 11'h0, row_preset}, 32'h0, "sync reset");
    host_bus_inst.ext_wr(8'h00, 8'h03);
    host_bus_inst.ext_rd(8'h8C, q); chk(q, 8'h00, "split after sync");
    host_bus_inst.ext_wr(8'h8B, 8'h1F);
    $display("test split done");
    host_bus_inst.ext_wr(8'h8E, 8'hFF);
    host_bus_inst.ext_wr(8'h8F, 8'h00);
    host_bus_inst.ext_rd(8'h8E, q); chk(q, GFX_REV, "rev g");
    host_bus_inst.ext_rd(8'h8F, q); chk(q, SEQ_REV, "rev s");
    host_bus_inst.crt_wr(8'h10, 8'h10);
    host_bus_inst.rd(10'h3D5, q); chk(q, 8'hA1, "crtc 10 read");
    host_bus_inst.ext_rd(8'h90, q); chk(q, 8'h10, "shadow 90");
    host_bus_inst.crt_wr(8'h11, 8'h14);
    host_bus_inst.rd(10'h3D5, q); chk(q, 8'hB2, "crtc 11 read");
    host_bus_inst.ext_rd(8'h91, q); chk(q, 8'h14, "shadow 91");
    $display("test access done");
    host_bus_inst.crt_wr(8'h18, 8'h20);
    frame(300);
    chk(16'(hi), 16'd8, "retrace width twice");
    chk(rise, 10'h010, "retrace start");
    chk(16'(ld), 16'd2, "row loads");
    chk(irq, 1'b1, "irq latched");
    host_bus_inst.rd(10'h3C2, q); chk(q[7], 1'b1, "status bit");
    host_bus_inst.ext_wr(8'h91, 8'h04);
    settle;
    chk(irq, 1'b0, "irq cleared");
    host_bus_inst.ext_wr(8'h91, 8'hB4);
    frame(300);
    chk(16'(hi), 16'd8, "test bit ignored");
    chk(irq, 1'b0, "irq disabled");
    adapter_vga = 0;
    frame(300);
    chk(16'(hi), 16'd0, "non vga state");
    adapter_vga = 1;
    host_bus_inst.crt_wr(8'h07, 8'h05);
    host_bus_inst.ext_wr(8'h91, 8'h14);
    frame(600);
    chk(rise, 10'h110, "ninth bit start");
    chk(16'(hi), 16'd4, "ninth bit width");
    host_bus_inst.ext_wr(8'h91, 8'h54);
    tick;
    chk(vline[8:7], 2'b11, "compat force");
    $display("test retrace done");
    end_sim;
  end
endmodule // display_extension_regs_tb

// File: verif/host_bus.sv
// host processor model issuing pc i/o port cycles
`timescale 1ns/1ps
module host_bus (
  input  wire logic       clk,
  input  wire logic [7:0] io_rdata,
  output logic      [9:0] io_addr,
  output logic            io_wr,
  output logic            io_rd,
  output logic      [7:0] io_wdata
);
  initial begin
    io_addr  = 10'h000;
    io_wr    = 1'b0;
    io_rd    = 1'b0;
    io_wdata = 8'h00;
  end
  // one-cycle strobe; released lines flip so stale values never look driven
  task automatic cyc(input logic [9:0] a, input logic [7:0] d, input logic rd,
                     output logic [7:0] q);
    @(negedge clk);
    io_addr  = a;
    io_wdata = d;
    io_wr    = !rd;
    io_rd    = rd;
    @(negedge clk);
    q        = io_rdata;
    io_wr    = 1'b0;
    io_rd    = 1'b0;
    io_addr  = ~a;
    io_wdata = ~d;
  endtask
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    logic [7:0] q;
    cyc(a, d, 1'b0, q);
  endtask
  task automatic rd(input logic [9:0] a, output logic [7:0] q);
    cyc(a, 8'h00, 1'b1, q);
  endtask
  task automatic ext_wr(input logic [7:0] i, input logic [7:0] d);
    wr(10'h3C4, i);
    wr(10'h3C5, d);
  endtask
  task automatic ext_rd(input logic [7:0] i, output logic [7:0] q);
    wr(10'h3C4, i);
    rd(10'h3C5, q);
  endtask
  task automatic crt_wr(input logic [7:0] i, input logic [7:0] d);
    wr(10'h3D4, i);
    wr(10'h3D5, d);
  endtask
endmodule // host_bus
